// [logic/dvd_pkg.sv]
// package: field positions, encodings and operation codes of the maintenance message decoder
package dvd_pkg;

    // ************************************************************
    // message field positions
    // ************************************************************
    localparam int ADDR_W        = 44;
    localparam int POS_COMPLETE  = 15;
    localparam int POS_TYPE_HI   = 14;
    localparam int POS_TYPE_LO   = 12;
    localparam int POS_HYP_HI    = 11;
    localparam int POS_HYP_LO    = 10;
    localparam int POS_SEC_HI    = 9;
    localparam int POS_SEC_LO    = 8;
    localparam int POS_RSV7      = 7;
    localparam int POS_VMID      = 6;
    localparam int POS_ASID      = 5;
    localparam int POS_LEAF      = 4;
    localparam int POS_STAGE_HI  = 3;
    localparam int POS_STAGE_LO  = 2;
    localparam int POS_RSV1      = 1;
    localparam int POS_MORE      = 0;
    localparam int POS_UPPER_LO  = 32;
    localparam int POS_VMID_HI   = 31;
    localparam int POS_VMID_LO   = 24;
    localparam int POS_ASID_HI   = 23;
    localparam int POS_ASID_LO   = 16;

    // ************************************************************
    // field encodings
    // ************************************************************
    localparam logic [2:0] TYPE_TLB   = 3'h0;
    localparam logic [2:0] TYPE_BP    = 3'h1;
    localparam logic [1:0] HYP_ALL    = 2'h0;
    localparam logic [1:0] HYP_MON    = 2'h1;
    localparam logic [1:0] HYP_GUEST  = 2'h2;
    localparam logic [1:0] HYP_HYP    = 2'h3;
    localparam logic [1:0] SEC_BOTH   = 2'h0;
    localparam logic [1:0] SEC_SECURE = 2'h2;
    localparam logic [1:0] SEC_NONSEC = 2'h3;
    localparam logic [1:0] STG_LEGACY = 2'h0;
    localparam logic [1:0] STG_S1     = 2'h1;
    localparam logic [1:0] STG_S2     = 2'h2;
    localparam logic [3:0] SNOOP_DVM  = 4'hf;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = '0;
    localparam logic [7:0]        BYTE_RST = 8'h00;

    // ************************************************************
    // decoded operations
    // ************************************************************
    typedef enum logic [4:0] {
        OP_NONE,
        OP_SEC_ALL, OP_SEC_VA, OP_SEC_ASID, OP_SEC_ASID_VA,
        OP_NS_ALL_OS, OP_GUEST_ALL_S1, OP_GUEST_ALL_S12, OP_GUEST_VA,
        OP_GUEST_ASID, OP_GUEST_ASID_VA, OP_GUEST_IPA,
        OP_HYP_ALL, OP_HYP_VA, OP_MON_ALL, OP_MON_VA,
        OP_BP_ALL, OP_BP_VA, OP_UNSUPPORTED
    } dvd_op_type;

    // incoming message beat
    typedef struct packed {
        logic [3:0]        snoop;
        logic [ADDR_W-1:0] addr;
    } dvd_msg_type;

    // decoded invalidate command
    typedef struct packed {
        dvd_op_type        op;
        logic              leaf_only;
        logic              stage1;
        logic              stage2;
        logic [7:0]        vmid;
        logic [7:0]        asid;
        logic [ADDR_W-1:0] addr;
    } dvd_cmd_type;

endpackage

// [logic/dvd_field_decode.sv]
// module: combinational mapping of one first beat onto an invalidate operation
module dvd_field_decode
    import dvd_pkg::*;
(
    // message beat
    input  wire logic [ADDR_W-1:0] addr,
    // decoded result
    output dvd_op_type             op,
    output logic                   leaf_only,
    output logic                   stage1,
    output logic                   stage2
);

    logic [2:0] mtype;
    logic [1:0] hyp;
    logic [1:0] sec;
    logic [1:0] stg;
    logic       vm;
    logic       as;
    logic       lf;
    logic       va;
    logic       tlb_fix_ok;
    logic       bp_fix_ok;

    // field extraction
    assign mtype = addr[POS_TYPE_HI:POS_TYPE_LO];
    assign hyp   = addr[POS_HYP_HI:POS_HYP_LO];
    assign sec   = addr[POS_SEC_HI:POS_SEC_LO];
    assign stg   = addr[POS_STAGE_HI:POS_STAGE_LO];
    assign vm    = addr[POS_VMID];
    assign as    = addr[POS_ASID];
    assign lf    = addr[POS_LEAF];
    assign va    = addr[POS_MORE];

    // fixed fields; a careless issuer is caught here, not trusted
    assign tlb_fix_ok = !addr[POS_COMPLETE] && !addr[POS_RSV7] && !addr[POS_RSV1]
                        && (addr[ADDR_W-1:POS_UPPER_LO] == '0); // [R2]
    assign bp_fix_ok  = tlb_fix_ok && (hyp == HYP_ALL) && (sec == SEC_BOTH)
                        && (addr[POS_LEAF:POS_RSV1] == 4'h0) && !vm && !as; // [R14] [R15] [R16]

    // operation table; anything unlisted falls to unsupported
    always_comb
    begin
        op        = OP_UNSUPPORTED; // [R20]
        leaf_only = 1'b0;
        stage1    = 1'b1;
        stage2    = 1'b1;
        if (mtype == TYPE_TLB && tlb_fix_ok) // [R1]
        begin
            if (hyp == HYP_GUEST && sec == SEC_SECURE && !vm && stg == STG_LEGACY)
            begin
                if (!as && !lf && !va)
                    op = OP_SEC_ALL; // [R3]
                else if (!as && va)
                    op = OP_SEC_VA; // [R4]
                else if (as && !lf && !va)
                    op = OP_SEC_ASID; // [R5]
                else if (as && va)
                    op = OP_SEC_ASID_VA; // [R5]
            end
            else if (hyp == HYP_GUEST && sec == SEC_NONSEC)
            begin
                if (!vm && !as && !lf && !va && stg == STG_LEGACY)
                    op = OP_NS_ALL_OS; // [R6]
                else if (vm && !as && !lf && !va && stg == STG_S1)
                begin
                    op     = OP_GUEST_ALL_S1; // [R7]
                    stage2 = 1'b0;
                end
                else if (vm && !as && !lf && !va && stg == STG_LEGACY)
                    op = OP_GUEST_ALL_S12; // [R8] [R13]
                else if (vm && stg == STG_LEGACY && (va || (as && !lf)))
                    op = as ? (va ? OP_GUEST_ASID_VA : OP_GUEST_ASID) : OP_GUEST_VA; // [R9]
                else if (vm && !as && va && stg == STG_S2)
                begin
                    op     = OP_GUEST_IPA; // [R10]
                    stage1 = 1'b0;
                end
            end
            else if (hyp == HYP_HYP && sec == SEC_NONSEC && !vm && !as
                     && stg == STG_LEGACY && (va || !lf))
                op = va ? OP_HYP_VA : OP_HYP_ALL; // [R11]
            else if (hyp == HYP_MON && sec == SEC_SECURE && !vm && !as
                     && stg == STG_LEGACY && (va || !lf))
                op = va ? OP_MON_VA : OP_MON_ALL; // [R12]
            if (op != OP_UNSUPPORTED)
                leaf_only = lf;
        end
        else if (mtype == TYPE_BP && bp_fix_ok)
            op = va ? OP_BP_VA : OP_BP_ALL; // [R17]
    end

endmodule

// [logic/dvd_decoder.sv]
// module: maintenance message decoder for translation and branch predictor invalidates
// Operation
// [R1] type code zero marks a translation invalidate message
// [R2] issuer keeps completion, reserved and upper address bits zero
// [R3] guest secure with all indicators clear invalidates all secure entries
// [R4] secure with address indicator invalidates by address, leaf-only if leaf set
// [R5] secure with ASID indicator invalidates by ASID, or ASID and address
// [R6] guest non-secure, indicators clear, invalidates all guest entries
// [R7] VMID with stage one code invalidates that machine's first stage only
// [R8] VMID invalidate-all with legacy stage code clears both stages
// [R9] VMID legacy stage invalidates by address, ASID, or both
// [R10] VMID with stage two code invalidates by intermediate address
// [R11] hypervisor non-secure invalidates all or by address
// [R12] monitor level secure invalidates all or by address
// [R13] legacy stage code zero carries no stage distinction
// [R14] predictor messages keep completion, scope and reserved bits zero
// [R15] predictor messages keep VMID and ASID indicators zero
// [R16] predictor invalidate with wide ASIDs is not honoured
// [R17] type code one invalidates whole predictor or by address
// [R18] address bit zero set means a second beat follows
// [R19] maintenance messages carry snoop type all ones
// [R20] unlisted combinations are flagged unsupported and cause no action
module dvd_decoder
    import dvd_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // message channel from the issuer
    input  wire logic        msg_valid,
    input  dvd_msg_type      msg,
    output logic             msg_ready,
    // decoded invalidate command
    output logic             cmd_valid,
    output dvd_cmd_type      cmd,
    output logic             cmd_unsupported
);

    // ************************************************************
    // state
    // ************************************************************
    // ST_SECOND holds a decoded first beat while its address beat is owed;
    // only a reset abandons a message left half sent
    typedef enum logic [0:0] {ST_FIRST, ST_SECOND} dvd_state_type;

    dvd_state_type  state_r,  state_nxt;
    dvd_cmd_type    held_r,   held_nxt;
    dvd_cmd_type    cmd_r,    cmd_nxt;
    logic           cvalid_r, cvalid_nxt;
    logic           unsup_r,  unsup_nxt;

    dvd_op_type     dec_op;
    logic           dec_leaf;
    logic           dec_s1;
    logic           dec_s2;
    logic           is_dvm;
    logic           take;

    // the decoder is never stalled; one beat per cycle is accepted
    assign msg_ready       = 1'b1;
    assign take            = msg_valid && msg_ready;
    assign is_dvm          = (msg.snoop == SNOOP_DVM); // [R19]
    assign cmd_valid       = cvalid_r;
    assign cmd             = cmd_r;
    assign cmd_unsupported = unsup_r;

    dvd_field_decode u_dec
    (
        .addr      (msg.addr),
        .op        (dec_op),
        .leaf_only (dec_leaf),
        .stage1    (dec_s1),
        .stage2    (dec_s2)
    );

    // ************************************************************
    // beat sequencing and command build
    // ************************************************************
    always_comb
    begin
        state_nxt  = state_r;
        held_nxt   = held_r;
        cmd_nxt    = cmd_r;
        cvalid_nxt = 1'b0;
        unsup_nxt  = 1'b0;
        if (take && state_r == ST_FIRST && is_dvm)
        begin
            held_nxt.op        = dec_op;
            held_nxt.leaf_only = dec_leaf;
            held_nxt.stage1    = dec_s1;
            held_nxt.stage2    = dec_s2;
            held_nxt.vmid      = msg.addr[POS_VMID] ? msg.addr[POS_VMID_HI:POS_VMID_LO]
                                                    : BYTE_RST;
            held_nxt.asid      = msg.addr[POS_ASID] ? msg.addr[POS_ASID_HI:POS_ASID_LO]
                                                    : BYTE_RST;
            held_nxt.addr      = ADDR_RST;
            if (msg.addr[POS_MORE])
                state_nxt = ST_SECOND; // [R18]
            else if (dec_op == OP_UNSUPPORTED)
                unsup_nxt = 1'b1; // [R20]
            else
            begin
                cmd_nxt    = held_nxt;
                cvalid_nxt = 1'b1;
            end
        end
        else if (take && state_r == ST_SECOND)
        begin
            // second beat carries the address; low nibble is not address
            state_nxt = ST_FIRST; // [R18]
            if (held_r.op == OP_UNSUPPORTED)
                unsup_nxt = 1'b1; // [R20]
            else
            begin
                // a refused message must not disturb the last command
                cmd_nxt      = held_r;
                cmd_nxt.addr = {msg.addr[ADDR_W-1:4], 4'h0};
                cvalid_nxt   = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_r  <= ST_FIRST;
            held_r   <= '{op: OP_NONE, default: '0};
            cmd_r    <= '{op: OP_NONE, default: '0};
            cvalid_r <= 1'b0;
            unsup_r  <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            held_r   <= held_nxt;
            cmd_r    <= cmd_nxt;
            cvalid_r <= cvalid_nxt;
            unsup_r  <= unsup_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_unsup_no_action: assert property (@(posedge ref_clk) disable iff (!reset_n)
        unsup_r |-> !cvalid_r) // [R20]
        else $error("unsupported message produced a command");

    a_single_beat_cmd: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && !msg.addr[POS_MORE]
         && msg.addr[POS_TYPE_HI:POS_TYPE_LO] == TYPE_TLB
         && msg.addr[POS_COMPLETE]) |=> !cvalid_r) // [R2]
        else $error("completion bit set yet command issued");

    a_second_beat: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && msg.addr[POS_MORE])
        |=> state_r == ST_SECOND && !cvalid_r && !unsup_r) // [R18]
        else $error("two-beat message not held for second beat");

    a_snoop_filter: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_FIRST && !is_dvm) |=> !cvalid_r && !unsup_r) // [R19]
        else $error("non-maintenance beat decoded");

    a_stage_one_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cvalid_r && cmd_r.op == OP_GUEST_ALL_S1) |-> cmd_r.stage1 && !cmd_r.stage2) // [R7]
        else $error("stage one invalidate touches stage two");

    a_legacy_both: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cvalid_r && cmd_r.op == OP_GUEST_ALL_S12) |-> cmd_r.stage1 && cmd_r.stage2) // [R8]
        else $error("legacy invalidate-all by machine misses a stage");

    a_ipa_stage_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cvalid_r && cmd_r.op == OP_GUEST_IPA) |-> !cmd_r.stage1 && cmd_r.stage2) // [R10]
        else $error("intermediate address invalidate has wrong stage");

    a_bp_no_ids: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cvalid_r && (cmd_r.op == OP_BP_ALL || cmd_r.op == OP_BP_VA))
        |-> cmd_r.vmid == BYTE_RST && cmd_r.asid == BYTE_RST && !cmd_r.leaf_only) // [R15]
        else $error("predictor command carries identifiers");

    a_sec_all_legal: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && msg.addr[15:0] == 16'h0a00
         && msg.addr[ADDR_W-1:POS_UPPER_LO] == '0)
        |=> cvalid_r && cmd_r.op == OP_SEC_ALL) // [R3]
        else $error("secure invalidate-all not decoded");

    a_type_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && !msg.addr[POS_MORE]
         && msg.addr[POS_TYPE_HI:POS_TYPE_LO] != TYPE_TLB
         && msg.addr[POS_TYPE_HI:POS_TYPE_LO] != TYPE_BP) |=> unsup_r) // [R1]
        else $error("foreign message type not refused");

    a_bp_all_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && msg.addr[15:0] == 16'h1000
         && msg.addr[ADDR_W-1:POS_UPPER_LO] == '0)
        |=> cvalid_r && cmd_r.op == OP_BP_ALL) // [R17]
        else $error("predictor invalidate-all not decoded");

    a_refused_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        unsup_r |-> $stable(cmd_r)) // [R20]
        else $error("refused message altered the held command");

    a_addr_aligned: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_SECOND && held_r.op != OP_UNSUPPORTED)
        |=> cvalid_r && cmd_r.addr[3:0] == 4'h0) // [R18]
        else $error("address beat not turned into an aligned command");

    a_leaf_needs_va: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cvalid_r && cmd_r.leaf_only)
        |-> cmd_r.op inside {OP_SEC_VA, OP_SEC_ASID_VA, OP_GUEST_VA, OP_GUEST_ASID_VA,
                             OP_GUEST_IPA, OP_HYP_VA, OP_MON_VA}) // [R4]
        else $error("leaf-only restriction on a command without an address");

    a_single_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (take && state_r == ST_FIRST && is_dvm && !msg.addr[POS_MORE])
        |=> cvalid_r || unsup_r) // [R20]
        else $error("single-beat message left without an answer");

endmodule

// [tb/dvd_issuer.sv]
// partner: issuer model that offers maintenance message beats
module dvd_issuer
    import dvd_pkg::*;
(
    // clock
    input  wire logic   ref_clk,
    // beats toward the decoder
    output logic        msg_valid,
    output dvd_msg_type msg
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet until the first message
    initial
    begin
        msg_valid = 1'b0;
        msg       = '0;
    end

    // first beat with completion, reserved and upper bits cleared
    function automatic logic [ADDR_W-1:0] compose(input logic [15:0] ids,
                                                  input logic [15:0] low);
        compose = {12'h0, ids, low & 16'h7f7d};
    endfunction

    // one beat, changed after the falling edge, held over the rising one
    task automatic beat(input logic [3:0] sn, input logic [ADDR_W-1:0] a);
        @(negedge ref_clk);
        msg_valid = 1'b1;
        msg       = '{sn, a};
    endtask

    // released lines show the inverse of their last value
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            msg_valid = 1'b0;
            msg       = ~msg;
        end
    endtask

    // whole message; address beat carries another snoop code on purpose
    task automatic send(input logic [3:0] sn, input logic [ADDR_W-1:0] a,
                        input logic [ADDR_W-1:0] a2, input int gap);
        beat(sn, a);
        if (a[0] && sn == SNOOP_DVM)
            beat(~sn, a2);
        idle(gap);
    endtask
endmodule

// [tb/tb_dvm_tlb_bp_invalidate_decoder.sv]
// bench: corner and random maintenance messages against a reference decode
module tb_dvm_tlb_bp_invalidate_decoder
    import dvd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk, reset_n, msg_valid, msg_ready;
    logic              cmd_valid, cmd_unsupported, e_v, e_u, pend, started;
    dvd_msg_type       msg;
    dvd_cmd_type       cmd, e_cmd;
    logic [ADDR_W-1:0] first_r;
    int                num_errors, n_tests, cyc;
    // every listed operation, then refused variants
    localparam logic [15:0] TBL [34] = '{16'h0a00, 16'h0a01, 16'h0a11, 16'h0a20,
        16'h0a21, 16'h0a31, 16'h0b00, 16'h0b44, 16'h0b40, 16'h0b41, 16'h0b51, 16'h0b60,
        16'h0b61, 16'h0b71, 16'h0b49, 16'h0b59, 16'h0f00, 16'h0f01, 16'h0f11, 16'h0600,
        16'h0601, 16'h0611, 16'h1000, 16'h1001, 16'h8a00, 16'h0a80, 16'h0a02, 16'h0a10,
        16'h0a0c, 16'h0900, 16'h1040, 16'h1010, 16'h1400, 16'h0b48};

    dvd_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n), .msg_valid(msg_valid),
        .msg(msg), .msg_ready(msg_ready), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_unsupported(cmd_unsupported));
    dvd_issuer u_iss (.ref_clk(ref_clk), .msg_valid(msg_valid), .msg(msg));

    // 200 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // expected operation of a first beat
    function automatic dvd_op_type ref_op(input logic [ADDR_W-1:0] a);
        logic [3:0] hs;
        logic [1:0] st;
        logic       v, s, l, va;
        hs = a[11:8];
        st = a[3:2];
        {v, s, l} = a[6:4];
        va = a[0];
        ref_op = OP_UNSUPPORTED;
        if (a[ADDR_W-1:32] != 0 || a[15] || a[7] || a[1] || (l && !va))
            ref_op = OP_UNSUPPORTED;
        else if (a[14:12] == TYPE_BP && hs == 4'h0 && a[6:1] == 6'h0)
            ref_op = va ? OP_BP_VA : OP_BP_ALL;
        else if (a[14:12] != TYPE_TLB || (st != STG_LEGACY && !(v && hs == 4'hb)))
            ref_op = OP_UNSUPPORTED;
        else if (hs == 4'ha && !v)
            ref_op = s ? (va ? OP_SEC_ASID_VA : OP_SEC_ASID) : (va ? OP_SEC_VA : OP_SEC_ALL);
        else if (hs == 4'hb && !v && !s && !va)
            ref_op = OP_NS_ALL_OS;
        else if (hs == 4'hb && v && st == STG_S1 && !s && !va)
            ref_op = OP_GUEST_ALL_S1;
        else if (hs == 4'hb && v && st == STG_S2 && !s && va)
            ref_op = OP_GUEST_IPA;
        else if (hs == 4'hb && v && st == STG_LEGACY)
            ref_op = s ? (va ? OP_GUEST_ASID_VA : OP_GUEST_ASID)
                       : (va ? OP_GUEST_VA : OP_GUEST_ALL_S12);
        else if (hs == 4'hf && !v && !s)
            ref_op = va ? OP_HYP_VA : OP_HYP_ALL;
        else if (hs == 4'h6 && !v && !s)
            ref_op = va ? OP_MON_VA : OP_MON_ALL;
    endfunction

    // expected pulse and command; a refused message leaves the command alone
    function automatic void expect_cmd(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] a2);
        dvd_op_type op;
        op  = ref_op(a);
        e_u = (op == OP_UNSUPPORTED);
        e_v = !e_u;
        if (e_v)
        begin
            e_cmd.op        = op;
            e_cmd.leaf_only = a[4];
            e_cmd.stage1    = op != OP_GUEST_IPA;
            e_cmd.stage2    = op != OP_GUEST_ALL_S1;
            e_cmd.vmid      = a[6] ? a[31:24] : 8'h00;
            e_cmd.asid      = a[5] ? a[23:16] : 8'h00;
            e_cmd.addr      = a[0] ? {a2[ADDR_W-1:4], 4'h0} : '0;
        end
    endfunction

    function automatic logic [ADDR_W-1:0] rnd_addr();
        rnd_addr = ADDR_W'({$urandom, $urandom});
    endfunction

    task automatic chk_val(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_op(input dvd_op_type got, input dvd_op_type exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // reference tracking of each beat taken at the rising edge; hang guard last
    always @(posedge ref_clk)
    begin
        started = 1'b1;
        e_v = 1'b0;
        e_u = 1'b0;
        if (!reset_n)
        begin
            pend  = 1'b0;
            e_cmd = '0;
        end
        else if (msg_valid && (pend || msg.snoop == SNOOP_DVM))
        begin
            if (!pend && msg.addr[0])
                first_r = msg.addr;
            else
                expect_cmd(pend ? first_r : msg.addr, msg.addr);
            pend = !pend && msg.addr[0];
        end
        cyc++;
        if (cyc > 10000)
        begin
            num_errors++;
            final_report();
        end
    end

    // outputs are settled by the falling edge
    always @(negedge ref_clk)
    begin
        if (started)
        begin
            chk_val(cmd_valid, e_v);
            chk_val(msg_ready, 1'b1);
            chk_val(cmd_unsupported, e_u);
            chk_op(cmd.op, e_cmd.op);
            chk_val(cmd.leaf_only, e_cmd.leaf_only);
            chk_val({cmd.vmid, cmd.asid}, {e_cmd.vmid, e_cmd.asid});
            chk_val(cmd.addr, e_cmd.addr);
            if (e_cmd.op != OP_BP_ALL && e_cmd.op != OP_BP_VA)
                chk_val({cmd.stage1, cmd.stage2}, {e_cmd.stage1, e_cmd.stage2});
        end
    end

    // main sequence
    initial
    begin
        logic [31:0]       r;
        logic [ADDR_W-1:0] a;
        {reset_n, started, pend, e_v, e_u} = '0;
        {cyc, num_errors, n_tests} = '0;
        e_cmd = '0;
        void'($urandom(8));
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        foreach (TBL[i])
            u_iss.send(SNOOP_DVM, {12'h0, 16'($urandom), TBL[i]}, rnd_addr(), 0);
        u_iss.send(SNOOP_DVM, 44'h100_0000_0a00, '0, 1);
        u_iss.send(4'he, 44'h0a01, rnd_addr(), 1);
        // reset while an address beat is still owed
        u_iss.beat(SNOOP_DVM, 44'h0a01);
        u_iss.idle(1);
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        u_iss.send(SNOOP_DVM, 44'h0a00, '0, 0);
        // random mix of legal and refused encodings, with stray bits and foreign snoop codes
        repeat (400)
        begin
            r = $urandom;
            a = u_iss.compose(16'($urandom), {3'h0, r[0], r[12] ? 12'h0 : r[11:0]});
            if (r[20:17] == 4'h0)
                a = a ^ (ADDR_W'(1) << (r[31:26] % ADDR_W));
            u_iss.send(r[25:23] == 3'h0 ? 4'h7 : SNOOP_DVM, a, rnd_addr(), int'(r[22:21]));
        end
        u_iss.idle(3);
        final_report();
    end
endmodule
